// ---- common/fgp_regs.vh ----
// register offsets, field positions and reset values of the flash guard block
`ifndef FGP_REGS_VH
`define FGP_REGS_VH
`define FGP_OFF_CTRL_LO 8'h00
`define FGP_OFF_CTRL_HI 8'h04
`define FGP_OFF_ADDR_LO 8'h08
`define FGP_OFF_ADDR_HI 8'h0C
`define FGP_OFF_DATA_LO 8'h10
`define FGP_OFF_DATA_HI 8'h14
`define FGP_OFF_SECT_LO 8'h18
`define FGP_OFF_SECT_HI 8'h1C
`define FGP_OFF_ERR 8'h20
`define FGP_OFF_FUSE_ACC 8'h24
`define FGP_OFF_FUSE_DIS 8'h28
`define FGP_OFF_FUSE_REN 8'h2C
`define FGP_OFF_FUSE_WPL 8'h30
`define FGP_OFF_FUSE_WPH 8'h34
`define FGP_OFF_VOL_ACC 8'h38
`define FGP_OFF_VOL_WP 8'h3C
`define FGP_OFF_FETCH 8'h40
// control word zero low fields
`define FGP_LO_BUSY 0
`define FGP_LO_BSYNV 1
`define FGP_LO_LOCK 4
// control word zero high fields
`define FGP_HI_WPG 12
`define FGP_HI_DWPG 11
`define FGP_HI_SER 10
`define FGP_HI_SPR 8
`define FGP_HI_SUSPEND_BIT 14
`define FGP_HI_START 15
`define FGP_SEL_MASK 16'h1D00
// error register field
`define FGP_ERR_RES 9
`define FGP_ERR_PROT 1
// access guard fuse fields
`define FGP_ACC_BIT 0
`define FGP_DBG_BIT 1
// fuse target addresses low half, high half is 000E
`define FGP_FA_WPL 16'hDFB4
`define FGP_FA_WPH 16'hDFB6
`define FGP_FA_ACC 16'hDFB8
`define FGP_FA_DIS 16'hDFBC
`define FGP_FA_REN 16'hDFBE
`define FGP_FA_HI 16'h000E
// fetch location codes
`define FGP_LOC_FLASH 2'h0
`define FGP_LOC_INTERNAL_RAM 2'h1
`define FGP_LOC_EXTENSION_RAM 2'h2
`define FGP_LOC_EXT 2'h3
`define FGP_TRAP_NUM 16'h009B
`define FGP_DUMMY 32'h00000000
`define FGP_RESET_FUSE 16'hFFFF
`define FGP_LOCK_CYC 5'h04
`define FGP_OP_CYC 5'h10
`endif

// ---- src/fgp_flash_guard.v ----
// flash access and write protection with axi4-lite register slave
`timescale 1ns/100ps
`include "fgp_regs.vh"
// Contract
// - guard fuse 0 lets flash data reads only when fetching from flash
// - guard suspended while disable fuse x is 0 and reenable fuse x is 1
// - disable fuse 0 programmable only after debug and access guard fuses are 0
// - disable fuse x programmable only after reenable fuse x-1 is 0
// - guard restored when reenable x is 0 and disable x+1 is 1
// - reenable fuse x programmable only after disable fuse x is 0
// - disable/reenable cycle possible at most sixteen times, one pair each
// - guarded flash writes from ram or external code are discarded
// - guarded flash reads from outside flash give dummy data and trap 009Bh
// - peripheral transfers to guarded flash blocked until temporary unprotect
// - outside code may read control registers but not write them
// - writes to a sector with write guard bit 0 are blocked
// - set-protection writing 1 lifts sector guard in volatile copy only
// - lifted guards return on reset or set-protection writing 0
// - temporary unprotect sets volatile copy, fuse stays 0
// - control registers denied while lock flag bit 4 reads 1
// - double word program ignores address bit two
// - program and erase suspend via suspend bit 0x4000
// - resume with changed select bits aborts and sets resume error flag
// - reset forces protections, then loads three volatile copies once
// - debug guard fuse 0 disables debug, test interface and test modes; here it only clears debug_enable_q
module fgp_flash_guard #(
  parameter SECTORS = 14
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cpu_req,
  input wire cpu_we,
  input wire cpu_pec,
  input wire [SECTORS-1:0] cpu_sector,
  input wire [31:0] flash_rdata,
  output reg cpu_ack,
  output reg [31:0] cpu_rdata,
  output reg cpu_discard,
  output reg trap_req,
  output reg [15:0] trap_num,
  output reg flash_rd,
  output reg flash_wr,
  output reg debug_enable_q
);
  localparam ST_LOAD = 4'b0001;
  localparam ST_IDLE = 4'b0010;
  localparam ST_RUN = 4'b0100;
  localparam ST_SUSPEND_BIT = 4'b1000;

  reg [3:0] state_q;
  reg [15:0] ctrl_hi_q, addr_lo_q, addr_hi_q, data_lo_q, data_hi_q;
  reg [15:0] sect_lo_q, sect_hi_q, err_q;
  reg [15:0] fuse_acc_q, fuse_dis_q, fuse_ren_q, fuse_wpl_q, fuse_wph_q;
  reg vol_acc_q;
  reg [SECTORS-1:0] vol_wp_q;
  reg [1:0] fetch_loc_q;
  reg [15:0] sel_saved_q;
  reg [4:0] lock_cnt_q;
  reg [4:0] op_cnt_q;
  reg [7:0] awaddr_q;
  reg aw_got_q, w_got_q;
  reg [31:0] wdata_q;
  wire [SECTORS-1:0] fuse_wp;
  wire from_flash;
  wire guard_on;
  wire lock;
  reg suspended_guard;
  integer i;

  assign fuse_wp = {fuse_wph_q[SECTORS-11:0], fuse_wpl_q[9:0]};
  assign from_flash = (fetch_loc_q == `FGP_LOC_FLASH);
  assign lock = (lock_cnt_q != 5'h00);

  // guard suspended by any pair that is still in the disabled stage
  always @* begin
    suspended_guard = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      if (!fuse_dis_q[i] && fuse_ren_q[i]) begin
        suspended_guard = 1'b1;
      end
    end
  end
  // reenable x with disable x+1 still erased leaves no suspended pair
  assign guard_on = !fuse_acc_q[`FGP_ACC_BIT] && !suspended_guard && !vol_acc_q;

  // one-time programming checks for the disable/reenable chain
  function [15:0] dis_allowed;
    input [15:0] acc;
    input [15:0] ren;
    integer k;
    begin
      dis_allowed[0] = !acc[`FGP_ACC_BIT] && !acc[`FGP_DBG_BIT];
      for (k = 1; k < 16; k = k + 1) begin
        dis_allowed[k] = !ren[k-1];
      end
    end
  endfunction

  wire [15:0] dis_ok = dis_allowed(fuse_acc_q, fuse_ren_q);
  wire [15:0] dis_new = fuse_dis_q & (data_lo_q | ~dis_ok);
  wire [15:0] ren_new = fuse_ren_q & (data_lo_q | fuse_dis_q);

  wire [7:0] waddr = awaddr_q;
  wire wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  // only flash-fetched code may write, and not while locked; the fetch register at 0x40 takes any write
  wire wr_ok = from_flash && !lock;
  wire [15:0] wlo = wdata_q[15:0];
  wire start = wr_fire && wr_ok && waddr == `FGP_OFF_CTRL_HI && wlo[`FGP_HI_START] && state_q == ST_IDLE;
  wire suspend_bit = wr_fire && wr_ok && waddr == `FGP_OFF_CTRL_HI && wlo[`FGP_HI_SUSPEND_BIT] && state_q == ST_RUN;
  wire resume = wr_fire && wr_ok && waddr == `FGP_OFF_CTRL_HI && wlo[`FGP_HI_START] && state_q == ST_SUSPEND_BIT;
  wire spr_op = ctrl_hi_q[`FGP_HI_SPR];
  wire suspend_bit_op = ctrl_hi_q[`FGP_HI_WPG] | ctrl_hi_q[`FGP_HI_DWPG] | ctrl_hi_q[`FGP_HI_SER];

  // axi write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_got_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        w_got_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // control registers, volatile copies and operation sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_LOAD;
      ctrl_hi_q <= 16'h0000;
      addr_lo_q <= 16'h0000;
      addr_hi_q <= 16'h0000;
      data_lo_q <= 16'h0000;
      data_hi_q <= 16'h0000;
      sect_lo_q <= 16'h0000;
      sect_hi_q <= 16'h0000;
      err_q <= 16'h0000;
      vol_acc_q <= 1'b0;
      vol_wp_q <= {SECTORS{1'b0}};
      sel_saved_q <= 16'h0000;
      lock_cnt_q <= 5'h00;
      op_cnt_q <= 5'h00;
      fetch_loc_q <= `FGP_LOC_FLASH;
      debug_enable_q <= 1'b0;
    end else begin
      if (lock_cnt_q != 5'h00) begin
        lock_cnt_q <= lock_cnt_q - 5'h01;
      end
      case (state_q)
        ST_LOAD: begin
          // volatile copies follow the fuse cells once after reset
          vol_acc_q <= 1'b0;
          vol_wp_q <= fuse_wp;
          debug_enable_q <= fuse_acc_q[`FGP_DBG_BIT];
          state_q <= ST_IDLE;
        end
        ST_IDLE: begin
          if (start) begin
            sel_saved_q <= ctrl_hi_q & `FGP_SEL_MASK;
            if (ctrl_hi_q[`FGP_HI_DWPG]) begin
              addr_lo_q[2] <= 1'b0;
            end
            lock_cnt_q <= `FGP_LOCK_CYC;
            op_cnt_q <= `FGP_OP_CYC;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (suspend_bit && suspend_bit_op) begin
            state_q <= ST_SUSPEND_BIT;
          end else if (op_cnt_q != 5'h00) begin
            op_cnt_q <= op_cnt_q - 5'h01;
          end else begin
            state_q <= ST_IDLE;
            ctrl_hi_q <= 16'h0000;
            if (ctrl_hi_q[`FGP_HI_SER]) begin
              sect_lo_q <= 16'h0000;
              sect_hi_q <= 16'h0000;
            end
            if (spr_op && addr_hi_q == `FGP_FA_HI) begin
              case (addr_lo_q)
                `FGP_FA_ACC: begin
                  // 1 lifts the volatile copy, 0 programs the fuse
                  vol_acc_q <= data_lo_q[`FGP_ACC_BIT];
                end
                `FGP_FA_WPL: begin
                  vol_wp_q[9:0] <= data_lo_q[9:0] & (fuse_wp[9:0] | data_lo_q[9:0]);
                end
                `FGP_FA_WPH: begin
                  vol_wp_q[SECTORS-1:10] <= data_lo_q[SECTORS-11:0];
                end
                default: begin
                  err_q[`FGP_ERR_PROT] <= (addr_lo_q == `FGP_FA_DIS) && (dis_new != (fuse_dis_q & data_lo_q));
                end
              endcase
            end
          end
        end
        ST_SUSPEND_BIT: begin
          if (resume) begin
            if ((ctrl_hi_q & `FGP_SEL_MASK) != sel_saved_q) begin
              err_q[`FGP_ERR_RES] <= 1'b1;
              ctrl_hi_q <= 16'h0000;
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_RUN;
            end
          end
        end
        default: state_q <= ST_LOAD;
      endcase
      if (wr_fire && wr_ok) begin
        case (waddr)
          `FGP_OFF_CTRL_HI: if (!start && !resume) ctrl_hi_q <= wlo & ~16'hC000;
          `FGP_OFF_ADDR_LO: addr_lo_q <= wlo;
          `FGP_OFF_ADDR_HI: addr_hi_q <= wlo;
          `FGP_OFF_DATA_LO: data_lo_q <= wlo;
          `FGP_OFF_DATA_HI: data_hi_q <= wlo;
          `FGP_OFF_SECT_LO: sect_lo_q <= wlo;
          `FGP_OFF_SECT_HI: sect_hi_q <= wlo;
          `FGP_OFF_ERR: if (state_q == ST_IDLE) err_q <= 16'h0000;
          default: begin end
        endcase
      end
      if (wr_fire && waddr == `FGP_OFF_FETCH) begin
        fetch_loc_q <= wdata_q[1:0];
      end
    end
  end

  // fuse cells: one-time, bits only go to 0, survive reset
  always @(posedge aclk) begin
    if (state_q == ST_RUN && op_cnt_q == 5'h00 && spr_op && addr_hi_q == `FGP_FA_HI) begin
      case (addr_lo_q)
        `FGP_FA_ACC: fuse_acc_q <= fuse_acc_q & (data_lo_q | 16'hFFFC);
        `FGP_FA_DIS: fuse_dis_q <= dis_new;
        `FGP_FA_REN: fuse_ren_q <= ren_new;
        `FGP_FA_WPL: fuse_wpl_q <= fuse_wpl_q & (data_lo_q | 16'hFC00);
        `FGP_FA_WPH: fuse_wph_q <= fuse_wph_q & (data_lo_q | 16'hFFFC);
        default: fuse_acc_q <= fuse_acc_q;
      endcase
    end
  end
  initial begin
    fuse_acc_q = `FGP_RESET_FUSE;
    fuse_dis_q = `FGP_RESET_FUSE;
    fuse_ren_q = `FGP_RESET_FUSE;
    fuse_wpl_q = `FGP_RESET_FUSE;
    fuse_wph_q = `FGP_RESET_FUSE;
  end

  // axi read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= lock ? 2'h2 : 2'h0;
      s_axi_rdata <= 32'h00000000;
      if (!lock) begin
        case (s_axi_araddr)
          `FGP_OFF_CTRL_LO: s_axi_rdata[15:0] <= {11'h000, lock, 2'h0, state_q[3], state_q[2] | state_q[3]};
          `FGP_OFF_CTRL_HI: s_axi_rdata[15:0] <= ctrl_hi_q | {state_q[3], 15'h0000};
          `FGP_OFF_ADDR_LO: s_axi_rdata[15:0] <= addr_lo_q;
          `FGP_OFF_ADDR_HI: s_axi_rdata[15:0] <= addr_hi_q;
          `FGP_OFF_DATA_LO: s_axi_rdata[15:0] <= data_lo_q;
          `FGP_OFF_DATA_HI: s_axi_rdata[15:0] <= data_hi_q;
          `FGP_OFF_SECT_LO: s_axi_rdata[15:0] <= sect_lo_q;
          `FGP_OFF_SECT_HI: s_axi_rdata[15:0] <= sect_hi_q;
          `FGP_OFF_ERR: s_axi_rdata[15:0] <= err_q;
          `FGP_OFF_FUSE_ACC: s_axi_rdata[15:0] <= fuse_acc_q;
          `FGP_OFF_FUSE_DIS: s_axi_rdata[15:0] <= fuse_dis_q;
          `FGP_OFF_FUSE_REN: s_axi_rdata[15:0] <= fuse_ren_q;
          `FGP_OFF_FUSE_WPL: s_axi_rdata[15:0] <= fuse_wpl_q;
          `FGP_OFF_FUSE_WPH: s_axi_rdata[15:0] <= fuse_wph_q;
          `FGP_OFF_VOL_ACC: s_axi_rdata[0] <= !guard_on;
          `FGP_OFF_VOL_WP: s_axi_rdata[SECTORS-1:0] <= vol_wp_q;
          `FGP_OFF_FETCH: s_axi_rdata[1:0] <= fetch_loc_q;
          default: s_axi_rresp <= 2'h2;
        endcase
      end
    end
  end

  // cpu and peripheral transfer access gate toward the flash array
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_ack <= 1'b0;
      cpu_rdata <= 32'h00000000;
      cpu_discard <= 1'b0;
      trap_req <= 1'b0;
      trap_num <= 16'h0000;
      flash_rd <= 1'b0;
      flash_wr <= 1'b0;
    end else begin
      cpu_ack <= cpu_req;
      trap_req <= 1'b0;
      flash_rd <= 1'b0;
      flash_wr <= 1'b0;
      cpu_discard <= 1'b0;
      cpu_rdata <= `FGP_DUMMY;
      if (cpu_req) begin
        if ((guard_on && (cpu_pec || !from_flash)) || state_q == ST_LOAD) begin
          cpu_discard <= 1'b1;
          if (!cpu_we && !cpu_pec) begin
            trap_req <= 1'b1;
            trap_num <= `FGP_TRAP_NUM;
          end
        end else if (cpu_we) begin
          if (|(cpu_sector & ~vol_wp_q)) begin
            cpu_discard <= 1'b1;
          end else begin
            flash_wr <= 1'b1;
          end
        end else begin
          flash_rd <= 1'b1;
          cpu_rdata <= flash_rdata;
        end
      end
    end
  end
endmodule

// ---- tb/fgp_flash_guard_sva.sv ----
// port assertions for the flash guard
`timescale 1ns/100ps
module fgp_guard_chk #(
  parameter SECTORS = 14
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire cpu_req,
  input wire cpu_we,
  input wire [31:0] flash_rdata,
  input wire cpu_ack,
  input wire [31:0] cpu_rdata,
  input wire cpu_discard,
  input wire trap_req,
  input wire [15:0] trap_num,
  input wire flash_rd,
  input wire flash_wr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  ack_after_req_a: assert property (cpu_req |=> cpu_ack) else $error("ack missing");
  ack_cause_a: assert property (cpu_ack |-> $past(cpu_req)) else $error("ack without request");
  trap_code_a: assert property (trap_req |-> trap_num == 16'h009B) else $error("trap number wrong");
  trap_dummy_a: assert property (trap_req |-> cpu_rdata == 32'h00000000 && !flash_rd)
    else $error("trap read not dummy");
  discard_block_a: assert property (cpu_discard |-> !flash_rd && !flash_wr) else $error("discard passed");
  idle_quiet_a: assert property (!cpu_req |=> !flash_rd && !flash_wr && !trap_req)
    else $error("array access without request");
  write_no_read_a: assert property (cpu_req && cpu_we |=> !flash_rd && !trap_req)
    else $error("write turned into read");
  read_data_a: assert property (flash_rd |-> cpu_rdata == $past(flash_rdata)) else $error("read data wrong");
  wr_answer_a: assert property (wr_both |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule
bind fgp_flash_guard fgp_guard_chk #(.SECTORS(SECTORS)) fgp_guard_chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .cpu_req, .cpu_we, .flash_rdata, .cpu_ack, .cpu_rdata, .cpu_discard, .trap_req, .trap_num, .flash_rd,
  .flash_wr);

// ---- tb/fgp_cpu_model.sv ----
// cpu core, transfer controller and array stand-in issuing one access at a time
`timescale 1ns/100ps
module fgp_cpu_model #(
  parameter SECTORS = 14,
  parameter [31:0] WORD = 32'h5A3C96E1
) (
  input wire aclk,
  output logic cpu_req,
  output logic cpu_we,
  output logic cpu_pec,
  output logic [SECTORS-1:0] cpu_sector,
  output logic [31:0] flash_rdata,
  input wire cpu_ack,
  input wire [31:0] cpu_rdata,
  input wire cpu_discard,
  input wire trap_req,
  input wire flash_rd,
  input wire flash_wr
);
  initial begin
    cpu_req = 1'b0;
    cpu_we = 1'b1;
    cpu_pec = 1'b1;
    cpu_sector = '1;
    flash_rdata = WORD;
  end
  // qualifiers flip once the request drops so stale values never help
  task automatic access(input logic we, input logic peripheral_transfer_controller, input logic [SECTORS-1:0] sec,
                        output logic [3:0] fl, output logic [31:0] rd);
    @(posedge aclk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_pec <= peripheral_transfer_controller;
    cpu_sector <= sec;
    @(posedge aclk);
    cpu_req <= 1'b0;
    cpu_we <= ~we;
    cpu_pec <= ~peripheral_transfer_controller;
    cpu_sector <= ~sec;
    while (cpu_ack !== 1'b1) @(posedge aclk);
    fl = {flash_rd, flash_wr, cpu_discard, trap_req};
    rd = cpu_rdata;
  endtask
endmodule

// ---- tb/tb_fgp_flash_guard.sv ----
// self-checking bench for the flash guard
`timescale 1ns/100ps
`include "fgp_regs.vh"
module tb_fgp_flash_guard;
  localparam SEC = 14;
  localparam [31:0] WORD = 32'h5A3C96E1;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, req, we, peripheral_transfer_controller, ack, disc, trap, frd, fwr, dbg;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, fdata, crd;
  wire [15:0] tnum;
  wire [SEC-1:0] sect;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] d;
  logic [3:0] fl;
  logic [1:0] r;
  fgp_flash_guard #(.SECTORS(SEC)) fgp_flash_guard_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_req(req), .cpu_we(we), .cpu_pec(peripheral_transfer_controller), .cpu_sector(sect),
    .flash_rdata(fdata), .cpu_ack(ack), .cpu_rdata(crd), .cpu_discard(disc), .trap_req(trap),
    .trap_num(tnum), .flash_rd(frd), .flash_wr(fwr), .debug_enable_q(dbg));
  fgp_cpu_model #(.SECTORS(SEC), .WORD(WORD)) fgp_cpu_model_i (.aclk(aclk), .cpu_req(req), .cpu_we(we),
    .cpu_pec(peripheral_transfer_controller), .cpu_sector(sect), .flash_rdata(fdata), .cpu_ack(ack), .cpu_rdata(crd),
    .cpu_discard(disc), .trap_req(trap), .flash_rd(frd), .flash_wr(fwr));
  initial forever #25 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      close_out();
    end
  end
  task close_out();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task rf(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    chk("register", {16'h0000, d[15:0]}, {16'h0000, e});
  endtask
  task idle(input logic [31:0] m);
    do rd(`FGP_OFF_CTRL_LO); while (r !== 2'b00 || (d & m) !== 32'h0);
  endtask
  task sp(input logic [15:0] lo, input logic [15:0] v);
    wr(`FGP_OFF_CTRL_HI, 32'h00000100);
    wr(`FGP_OFF_ADDR_LO, {16'h0000, lo});
    wr(`FGP_OFF_ADDR_HI, {16'h0000, `FGP_FA_HI});
    wr(`FGP_OFF_DATA_LO, {16'h0000, v});
    wr(`FGP_OFF_CTRL_HI, 32'h00008100);
    idle(32'h00000013);
  endtask
  task fe(input logic [1:0] l);
    wr(`FGP_OFF_FETCH, {30'h0, l});
  endtask
  task rst();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  // a trapped read may also count as discarded, so that bit is not judged then
  task cx(input logic w, input logic p, input logic [SEC-1:0] s, input logic [3:0] ef, input logic [31:0] ed);
    fgp_cpu_model_i.access(w, p, s, fl, d);
    chk("gate flags", {28'h0, fl & {2'b11, ~ef[0], 1'b1}}, {28'h0, ef});
    if (ef[3] | ef[0])
      chk("cpu data", d, ed);
  endtask
  task t_reset();
    rf(`FGP_OFF_FUSE_ACC, 16'hFFFF);
    rf(`FGP_OFF_FUSE_DIS, 16'hFFFF);
    rf(`FGP_OFF_FUSE_REN, 16'hFFFF);
    rd(8'hFC);
    chk("unmapped", {30'h0, r}, 32'h2);
    chk("debug enable", {31'h0, dbg}, 32'h1);
    fe(2'h1);
    cx(1'b0, 1'b0, 14'h0001, 4'b1000, WORD);
    fe(2'h0);
  endtask
  task t_order();
    sp(`FGP_FA_DIS, 16'hFFFE);
    rf(`FGP_OFF_ERR, 16'h0002);
    rf(`FGP_OFF_FUSE_DIS, 16'hFFFF);
    sp(`FGP_FA_REN, 16'hFFFE);
    rf(`FGP_OFF_FUSE_REN, 16'hFFFF);
    wr(`FGP_OFF_ERR, 32'h0);
  endtask
  task t_arm();
    sp(`FGP_FA_ACC, 16'hFFFC);
    rst();
    chk("debug enable", {31'h0, dbg}, 32'h0);
    rf(`FGP_OFF_FUSE_ACC, 16'hFFFC);
    for (int l = 1; l < 4; l++) begin
      fe(l[1:0]);
      cx(1'b0, 1'b0, 14'h0001, 4'b0001, 32'h0);
      cx(1'b1, 1'b0, 14'h0001, 4'b0010, 32'h0);
    end
    wr(`FGP_OFF_CTRL_HI, 32'h00000100);
    chk("ctrl write", {30'h0, r}, 32'h2);
    rd(`FGP_OFF_CTRL_LO);
    chk("ctrl read", {30'h0, r}, 32'h0);
    fe(2'h0);
    cx(1'b0, 1'b0, 14'h0001, 4'b1000, WORD);
    cx(1'b0, 1'b1, 14'h0001, 4'b0010, 32'h0);
  endtask
  task t_temp();
    sp(`FGP_FA_ACC, 16'hFFFD);
    cx(1'b0, 1'b1, 14'h0001, 4'b1000, WORD);
    rf(`FGP_OFF_FUSE_ACC, 16'hFFFC);
    sp(`FGP_FA_ACC, 16'hFFFC);
    cx(1'b0, 1'b1, 14'h0001, 4'b0010, 32'h0);
  endtask
  task t_cycle();
    sp(`FGP_FA_DIS, 16'hFFFE);
    rf(`FGP_OFF_FUSE_DIS, 16'hFFFE);
    rst();
    fe(2'h1);
    cx(1'b0, 1'b0, 14'h0001, 4'b1000, WORD);
    fe(2'h0);
    sp(`FGP_FA_DIS, 16'hFFFC);
    rf(`FGP_OFF_FUSE_DIS, 16'hFFFE);
    wr(`FGP_OFF_ERR, 32'h0);
    sp(`FGP_FA_REN, 16'hFFFE);
    rf(`FGP_OFF_FUSE_REN, 16'hFFFE);
    rst();
    fe(2'h1);
    cx(1'b0, 1'b0, 14'h0001, 4'b0001, 32'h0);
    fe(2'h0);
  endtask
  task t_wp();
    sp(`FGP_FA_WPL, 16'hFFFE);
    rst();
    cx(1'b1, 1'b0, 14'h0001, 4'b0010, 32'h0);
    cx(1'b1, 1'b0, 14'h0002, 4'b0100, 32'h0);
    sp(`FGP_FA_WPL, 16'hFFFF);
    cx(1'b1, 1'b0, 14'h0001, 4'b0100, 32'h0);
  endtask
  task t_suspend_bit();
    wr(`FGP_OFF_SECT_LO, 32'h00000003);
    wr(`FGP_OFF_CTRL_HI, 32'h00000400);
    wr(`FGP_OFF_CTRL_HI, 32'h00008400);
    idle(32'h00000010);
    wr(`FGP_OFF_CTRL_HI, 32'h00004400);
    rd(`FGP_OFF_CTRL_LO);
    chk("suspended", {30'h0, d[1:0]}, 32'h3);
    rf(`FGP_OFF_SECT_LO, 16'h0003);
    wr(`FGP_OFF_CTRL_HI, 32'h00000800);
    wr(`FGP_OFF_CTRL_HI, 32'h00008800);
    rd(`FGP_OFF_ERR);
    chk("resume error", {31'h0, d[9]}, 32'h1);
    wr(`FGP_OFF_ADDR_LO, 32'h00000004);
    wr(`FGP_OFF_CTRL_HI, 32'h00000800);
    wr(`FGP_OFF_CTRL_HI, 32'h00008800);
    idle(32'h00000013);
    rf(`FGP_OFF_ADDR_LO, 16'h0000);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_order();
    t_arm();
    t_temp();
    t_cycle();
    t_wp();
    t_suspend_bit();
    close_out();
  end
endmodule
